// *** scds_top.v ***
// Command decoder and status reporting for a SCSI protocol controller,
// reached over APB with one byte register per aligned word.
// Assumes a sequence engine on pclk driving the engine inputs, and
// SCSI phase and bus reset lines arriving unsynchronised from pins.
//
// Summary of operation
// R1 - DMA flag copies start count into remaining count, decremented per byte.
// R2 - Low seven command bits decode 29 commands in four groups.
// R3 - Initiator codes 10,11,12,18,1A,1B.
// R4 - Target codes 20-25,27-2B; code 04 stops DMA.
// R5 - Selection codes 40 to 46.
// R6 - General codes 00 to 03.
// R7 - Status held until cause read; stacked second interrupt loads on read.
// R8 - Host reads status on every interrupt to find the source.
// R9 - Status bit 7 follows interrupt; cause read or reset clears it.
// R10 - Bit 6 flags illegal operations without interrupt; cleared by cause read.
// R11 - Bit 5 flags parity error when checking enabled; no interrupt.
// R12 - Initiator parity error during information phase asserts ATN.
// R13 - Bit 4 set at count zero, cleared on load; cause read keeps it.
// R14 - DMA no-operation reloads counter; plain no-operation leaves flag.
// R15 - Bit 3 marks standard group code; group 2 valid with feature bit.
// R16 - Groups 3,4 reserved six-byte; 6 vendor six-byte; 7 vendor ten-byte.
// R17 - Bits 2:0 report message, command/data and in/out phase lines.
// R18 - Latched phase frozen at command end until cause read; else live.
// R19 - Write-only target ID in bits 2:0; bits 7:3 reserved.
// R20 - Target ID undefined at power-up and kept through resets.
// R21 - Cause read clears cause, status and sequence step registers.
// R22 - Cause bit 7 on bus reset when reporting enabled.
// R23 - Cause bit 6 on undefined code or command of wrong mode.
// R24 - Two-deep queue; reset device and stop DMA bypass it.
// R25 - Invalid command starts nothing and leaves mode and counters alone.
`timescale 1ns/1ps
`include "scds_defs.vh"

module scds_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [1:0] engine_mode,
  input wire cmd_done,
  input wire [5:0] done_cause,
  input wire byte_xfer,
  input wire step_wr,
  input wire [2:0] step_in,
  input wire parity_err,
  input wire dir_err,
  input wire fifo_ovf,
  input wire sync_phase_err,
  input wire cdb_seen,
  input wire [2:0] cdb_group,
  input wire [2:0] scsi_phase_pin,
  input wire scsi_rst_pin,
  output reg irq,
  output reg atn_out,
  output reg cmd_start,
  output reg [7:0] cmd_code,
  output reg dma_stop,
  output reg soft_reset,
  output reg count_zero,
  output reg [3:0] cdb_len,
  output reg [2:0] target_id
);

  localparam ST_IDLE = 3'b001;
  localparam ST_BUSY = 3'b010;
  localparam ST_FULL = 3'b100;

  function known_cmd;
    input [6:0] c;
    begin
      case (c) // see R2
        `SCDS_C_NOP, `SCDS_C_CLR_FIFO, `SCDS_C_RST_DEV, `SCDS_C_RST_BUS: known_cmd = 1'b1; // see R6
        `SCDS_C_DMA_STOP: known_cmd = 1'b1;
        `SCDS_C_INFO_XFER, `SCDS_C_I_CC_STEPS, `SCDS_C_MSG_ACC, `SCDS_C_PAD,
        `SCDS_C_SET_ATN, `SCDS_C_CLR_ATN: known_cmd = 1'b1; // see R3
        `SCDS_C_SEND_MSG, `SCDS_C_SEND_STAT, `SCDS_C_SEND_DATA, `SCDS_C_DISC_STEPS,
        `SCDS_C_TERM_STEPS, `SCDS_C_T_CC_STEPS, `SCDS_C_DISC, `SCDS_C_RX_MSG_STEPS,
        `SCDS_C_RX_CMD, `SCDS_C_RX_DATA, `SCDS_C_RX_CMD_STEPS: known_cmd = 1'b1; // see R4
        `SCDS_C_RESEL_STEPS, `SCDS_C_SEL, `SCDS_C_SEL_ATN, `SCDS_C_SEL_ATN_STOP,
        `SCDS_C_EN_SEL, `SCDS_C_DIS_SEL, `SCDS_C_SEL_ATN3: known_cmd = 1'b1; // see R5
        default: known_cmd = 1'b0;
      endcase
    end
  endfunction

  // Group bit picks the mode the command belongs to
  function cmd_ok;
    input [6:0] c;
    input [1:0] m;
    begin
      if (!known_cmd(c))
        cmd_ok = 1'b0;
      else if (c[6])
        cmd_ok = (m == `SCDS_MODE_IDLE); // see R23
      else if (c[5])
        cmd_ok = (m == `SCDS_MODE_TARG);
      else if (c[4])
        cmd_ok = (m == `SCDS_MODE_INIT);
      else
        cmd_ok = 1'b1;
    end
  endfunction

  reg [2:0] ph_s1_r, ph_s2_r;
  reg rst_s1_r, rst_s2_r, rst_s3_r;
  reg [2:0] st_r, st_nxt;
  reg [7:0] pend_r, pend_nxt;
  reg [7:0] cur_cmd_r;
  reg [16:0] rem_r;
  reg [15:0] start_cnt_r;
  reg [7:0] ctrl_one_r, ctrl_two_r;
  reg [7:0] cause_r, cause2_r;
  reg ioe_r, pe_r, gcv_r, lat_closed_r;
  reg [2:0] phase_lat_r, step_r;
  reg launch, overwrite;
  reg [7:0] launch_code;
  reg [7:0] rd_mux;
  reg idx_ok;

  wire [3:0] idx = paddr[5:2];
  wire wr_done = psel & penable & pready & pwrite;
  wire rd_done = psel & penable & pready & ~pwrite;
  wire [7:0] wdata = pwdata[7:0];
  wire cmd_wr = wr_done && idx == `SCDS_IDX_CMD;
  // Reset device and stop DMA act at once, never queued; see R24
  wire bypass_rst = cmd_wr && wdata[6:0] == `SCDS_C_RST_DEV;
  wire bypass_stop = cmd_wr && wdata[6:0] == `SCDS_C_DMA_STOP;
  wire cmd_q = cmd_wr && !bypass_rst && !bypass_stop;
  wire cause_rd = rd_done && idx == `SCDS_IDX_CAUSE;
  wire launch_ok = launch && cmd_ok(launch_code[6:0], engine_mode);
  wire bad_cmd = launch && !launch_ok;
  wire phase_latch_enable = ctrl_two_r[`SCDS_C2_LSP_BIT];
  wire [2:0] phase_shown = phase_latch_enable ? phase_lat_r : ph_s2_r; // see R18
  wire rst_rise = rst_s2_r & ~rst_s3_r;
  wire [7:0] ev;
  wire [7:0] cause_left = cause_r & ~prdata[7:0];
  wire [7:0] cause_base = cause_rd ? (cause_left | cause2_r) : cause_r;
  wire [7:0] status_v = {irq, ioe_r, pe_r, count_zero, gcv_r, phase_shown}; // see R17

  // Rising edge only, so a bus reset held for long reports once
  assign ev[`SCDS_CAUSE_RST_BIT] = rst_rise & ctrl_one_r[`SCDS_C1_RST_RPT_BIT]; // see R22
  assign ev[`SCDS_CAUSE_BAD_BIT] = bad_cmd; // see R23
  assign ev[5:0] = cmd_done ? done_cause : 6'h00;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_s1_r <= 3'h0;
      ph_s2_r <= 3'h0;
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
      rst_s3_r <= 1'b0;
    end else begin
      ph_s1_r <= scsi_phase_pin;
      ph_s2_r <= ph_s1_r;
      rst_s1_r <= scsi_rst_pin;
      rst_s2_r <= rst_s1_r;
      rst_s3_r <= rst_s2_r;
    end
  end

  // Queue control; an invalid launch also drops the waiting command
  always @* begin
    launch = 1'b0;
    launch_code = pend_r;
    overwrite = 1'b0;
    st_nxt = st_r;
    pend_nxt = pend_r;
    case (st_r)
      ST_IDLE: begin
        if (cmd_q) begin
          launch = 1'b1;
          launch_code = wdata;
        end
      end
      ST_BUSY: begin
        if (cmd_q && cmd_done) begin
          launch = 1'b1;
          launch_code = wdata;
        end else if (cmd_q) begin
          pend_nxt = wdata; // see R24
          st_nxt = ST_FULL;
        end else if (cmd_done) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_FULL: begin
        if (cmd_done) begin
          launch = 1'b1;
          st_nxt = cmd_q ? ST_FULL : ST_BUSY;
          if (cmd_q)
            pend_nxt = wdata;
        end else if (cmd_q) begin
          pend_nxt = wdata;
          overwrite = 1'b1; // see R10
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
    if (launch) begin
      if (!cmd_ok(launch_code[6:0], engine_mode))
        st_nxt = ST_IDLE; // see R25
      else if (st_r == ST_FULL && cmd_q)
        st_nxt = ST_FULL;
      else
        st_nxt = ST_BUSY;
    end
  end

  always @* begin
    idx_ok = 1'b1;
    case (idx)
      `SCDS_IDX_COUNT_LO: rd_mux = rem_r[7:0];
      `SCDS_IDX_COUNT_HI: rd_mux = rem_r[15:8];
      `SCDS_IDX_CMD: rd_mux = cur_cmd_r; // see R24
      `SCDS_IDX_STATUS: rd_mux = status_v;
      `SCDS_IDX_CAUSE: rd_mux = cause_r;
      `SCDS_IDX_STEP: rd_mux = {5'h00, step_r};
      `SCDS_IDX_CTRL_ONE: rd_mux = ctrl_one_r;
      `SCDS_IDX_CTRL_TWO: rd_mux = ctrl_two_r;
      default: begin
        rd_mux = `SCDS_BYTE_ZERO;
        idx_ok = 1'b0;
      end
    endcase
  end

  // One-cycle access phase: answer is prepared during setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~idx_ok;
      if (psel & ~penable & ~pwrite)
        prdata <= {24'h00_0000, rd_mux};
    end
  end

  // Survive both resets
  always @(posedge pclk) begin
    if (wr_done && idx == `SCDS_IDX_TARGET_ID)
      target_id <= wdata[2:0]; // see R19 see R20
    if (wr_done && idx == `SCDS_IDX_COUNT_LO)
      start_cnt_r[7:0] <= wdata;
    if (wr_done && idx == `SCDS_IDX_COUNT_HI)
      start_cnt_r[15:8] <= wdata;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_one_r <= `SCDS_CTRL_RST;
      ctrl_two_r <= `SCDS_CTRL_RST;
    end else begin
      if (wr_done && idx == `SCDS_IDX_CTRL_ONE)
        ctrl_one_r <= wdata;
      if (wr_done && idx == `SCDS_IDX_CTRL_TWO)
        ctrl_two_r <= wdata;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_IDLE;
      pend_r <= `SCDS_BYTE_ZERO;
      cur_cmd_r <= `SCDS_BYTE_ZERO;
      cmd_start <= 1'b0;
      cmd_code <= `SCDS_BYTE_ZERO;
      dma_stop <= 1'b0;
      soft_reset <= 1'b0;
      rem_r <= 17'h0_0000;
      count_zero <= 1'b0;
      irq <= 1'b0;
      cause_r <= `SCDS_BYTE_ZERO;
      cause2_r <= `SCDS_BYTE_ZERO;
      ioe_r <= 1'b0;
      pe_r <= 1'b0;
      gcv_r <= 1'b0;
      lat_closed_r <= 1'b0;
      phase_lat_r <= 3'h0;
      step_r <= 3'h0;
      atn_out <= 1'b0;
      cdb_len <= 4'h6;
    end else if (bypass_rst) begin
      st_r <= ST_IDLE;
      cur_cmd_r <= wdata;
      soft_reset <= 1'b1;
      cmd_start <= 1'b0;
      dma_stop <= 1'b0;
      count_zero <= 1'b0;
      irq <= 1'b0; // see R9
      cause_r <= `SCDS_BYTE_ZERO;
      cause2_r <= `SCDS_BYTE_ZERO;
      ioe_r <= 1'b0;
      pe_r <= 1'b0;
      gcv_r <= 1'b0;
      lat_closed_r <= 1'b0;
      step_r <= 3'h0;
      atn_out <= 1'b0;
    end else begin
      st_r <= st_nxt;
      pend_r <= pend_nxt;
      soft_reset <= 1'b0;
      dma_stop <= bypass_stop; // see R4
      cmd_start <= launch_ok;
      if (bypass_stop)
        cur_cmd_r <= wdata;
      else if (launch)
        cur_cmd_r <= launch_code;
      if (launch_ok)
        cmd_code <= launch_code;
      // Load beats a decrement landing in the same cycle
      if (launch_ok && launch_code[`SCDS_CMD_DMA_BIT]) begin
        rem_r <= (start_cnt_r == 16'h0000) ? `SCDS_COUNT_FULL : {1'b0, start_cnt_r}; // see R1
        count_zero <= 1'b0; // see R13 see R14
      end else if (byte_xfer && rem_r != 17'h0_0000) begin
        rem_r <= rem_r - 17'h0_0001; // see R1
        if (rem_r == 17'h0_0001)
          count_zero <= 1'b1; // see R13
      end
      // Cause bits: new events win over the read clear
      if (irq && !cause_rd && |ev) begin
        cause2_r <= cause2_r | ev; // see R7
      end else begin
        cause_r <= cause_base | ev; // see R21
        if (cause_rd)
          cause2_r <= `SCDS_BYTE_ZERO;
        irq <= |(cause_base | ev); // see R9
      end
      ioe_r <= (ioe_r & ~cause_rd) | dir_err | fifo_ovf | overwrite
               | (sync_phase_err & engine_mode == `SCDS_MODE_INIT); // see R10
      pe_r <= (pe_r & ~cause_rd) | (parity_err & ctrl_one_r[`SCDS_C1_PAR_EN_BIT]); // see R11
      if (cdb_seen) begin
        gcv_r <= cdb_group == 3'h0 || cdb_group == 3'h1 || cdb_group == 3'h5
                 || (cdb_group == 3'h2 && ctrl_two_r[`SCDS_C2_SCSI2_FEATURE_ENABLE_BIT]); // see R15
        case (cdb_group) // see R16
          3'h1, 3'h7: cdb_len <= 4'hA;
          3'h2: cdb_len <= ctrl_two_r[`SCDS_C2_SCSI2_FEATURE_ENABLE_BIT] ? 4'hA : 4'h6;
          3'h5: cdb_len <= 4'hC;
          default: cdb_len <= 4'h6;
        endcase
      end else if (cause_rd) begin
        gcv_r <= 1'b0;
      end
      if (step_wr)
        step_r <= step_in;
      else if (cause_rd)
        step_r <= 3'h0; // see R21
      // Latch frozen from command end until the cause read reopens it
      if (cmd_done && phase_latch_enable)
        lat_closed_r <= 1'b1; // see R18
      else if (cause_rd)
        lat_closed_r <= 1'b0;
      if (!lat_closed_r)
        phase_lat_r <= ph_s2_r;
      if (parity_err && ctrl_one_r[`SCDS_C1_PAR_EN_BIT] && engine_mode == `SCDS_MODE_INIT)
        atn_out <= 1'b1; // see R12
      else if (launch_ok && launch_code[6:0] == `SCDS_C_SET_ATN)
        atn_out <= 1'b1; // see R3
      else if (launch_ok && launch_code[6:0] == `SCDS_C_CLR_ATN)
        atn_out <= 1'b0;
    end
  end

endmodule

// *** scds_defs.vh ***
// Constants of the command decoder and status block: register indices,
// field positions, reset values and command codes.
// Assumes inclusion by bare name from the design, monitor and bench files.
`ifndef SCDS_DEFS_VH
`define SCDS_DEFS_VH

// Register indices; byte address is four times the index
`define SCDS_IDX_COUNT_LO 4'h0
`define SCDS_IDX_COUNT_HI 4'h1
`define SCDS_IDX_CMD 4'h3
`define SCDS_IDX_STATUS 4'h4
`define SCDS_IDX_TARGET_ID 4'h4
`define SCDS_IDX_CAUSE 4'h5
`define SCDS_IDX_STEP 4'h6
`define SCDS_IDX_CTRL_ONE 4'h8
`define SCDS_IDX_CTRL_TWO 4'hB

// Field positions
`define SCDS_CMD_DMA_BIT 7
`define SCDS_ST_INT_BIT 7
`define SCDS_ST_IOE_BIT 6
`define SCDS_ST_PE_BIT 5
`define SCDS_ST_CZ_BIT 4
`define SCDS_ST_GCV_BIT 3
`define SCDS_C1_PAR_EN_BIT 4
`define SCDS_C1_RST_RPT_BIT 6
`define SCDS_C2_SCSI2_FEATURE_ENABLE_BIT 3
`define SCDS_C2_LSP_BIT 6
`define SCDS_CAUSE_RST_BIT 7
`define SCDS_CAUSE_BAD_BIT 6

// Reset values, and the full count loaded for a zero start count
`define SCDS_CTRL_RST 8'h00
`define SCDS_BYTE_ZERO 8'h00
`define SCDS_COUNT_FULL 17'h1_0000

// Engine modes
`define SCDS_MODE_IDLE 2'h0
`define SCDS_MODE_INIT 2'h1
`define SCDS_MODE_TARG 2'h2

// Command codes, low seven bits
`define SCDS_C_NOP 7'h00
`define SCDS_C_CLR_FIFO 7'h01
`define SCDS_C_RST_DEV 7'h02
`define SCDS_C_RST_BUS 7'h03
`define SCDS_C_DMA_STOP 7'h04
`define SCDS_C_INFO_XFER 7'h10
`define SCDS_C_I_CC_STEPS 7'h11
`define SCDS_C_MSG_ACC 7'h12
`define SCDS_C_PAD 7'h18
`define SCDS_C_SET_ATN 7'h1A
`define SCDS_C_CLR_ATN 7'h1B
`define SCDS_C_SEND_MSG 7'h20
`define SCDS_C_SEND_STAT 7'h21
`define SCDS_C_SEND_DATA 7'h22
`define SCDS_C_DISC_STEPS 7'h23
`define SCDS_C_TERM_STEPS 7'h24
`define SCDS_C_T_CC_STEPS 7'h25
`define SCDS_C_DISC 7'h27
`define SCDS_C_RX_MSG_STEPS 7'h28
`define SCDS_C_RX_CMD 7'h29
`define SCDS_C_RX_DATA 7'h2A
`define SCDS_C_RX_CMD_STEPS 7'h2B
`define SCDS_C_RESEL_STEPS 7'h40
`define SCDS_C_SEL 7'h41
`define SCDS_C_SEL_ATN 7'h42
`define SCDS_C_SEL_ATN_STOP 7'h43
`define SCDS_C_EN_SEL 7'h44
`define SCDS_C_DIS_SEL 7'h45
`define SCDS_C_SEL_ATN3 7'h46

`endif

// *** scds_top_monitor.sv ***
// Checker for the command decoder and status block, bound to its top.
// Sees only top-level ports; one clock, asynchronous active-low reset.
`timescale 1ns/1ps
`include "scds_defs.vh"
module scds_top_monitor (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire cmd_done,
  input wire [5:0] done_cause,
  input wire byte_xfer,
  input wire irq,
  input wire atn_out,
  input wire cmd_start,
  input wire [7:0] cmd_code,
  input wire dma_stop,
  input wire soft_reset,
  input wire count_zero
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable && pready;
  wire [3:0] idx = paddr[5:2];
  wire cmd_wr = acc && pwrite && idx == `SCDS_IDX_CMD;
  wire cause_rd = acc && !pwrite && idx == `SCDS_IDX_CAUSE;
  wire quiet = !cmd_start && !cmd_done;
  reg busy_r;
  // A queued write launches later, so only judge writes to an idle queue
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_r <= 1'b0;
    end else if (cmd_start) begin
      busy_r <= 1'b1;
    end else if (cmd_done || soft_reset) begin
      busy_r <= 1'b0;
    end
  end
  property p_status_irq;
    acc && !pwrite && idx == `SCDS_IDX_STATUS |-> prdata[7] == $past(irq);
  endproperty
  a_status_irq: assert property (p_status_irq) else $error("status bit 7 not irq");
  property p_done_irq;
    cmd_done && done_cause != 6'h00 && !cmd_wr |=> irq;
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("no irq after done");
  property p_cz_rise;
    $rose(count_zero) |-> $past(byte_xfer);
  endproperty
  a_cz_rise: assert property (p_cz_rise) else $error("count zero rose alone");
  property p_cause_keeps_cz;
    cause_rd && !byte_xfer && !cmd_done |=> $stable(count_zero);
  endproperty
  a_cause_keeps_cz: assert property (p_cause_keeps_cz) else $error("cause read moved cz");
  property p_dma_load;
    cmd_start && cmd_code[7] |-> !count_zero;
  endproperty
  a_dma_load: assert property (p_dma_load) else $error("dma launch kept cz");
  property p_stop_now;
    cmd_wr && pwdata[6:0] == 7'h04 |=> dma_stop;
  endproperty
  a_stop_now: assert property (p_stop_now) else $error("stop not at once");
  property p_soft;
    cmd_wr && pwdata[6:0] == 7'h02 && !cmd_done |=> soft_reset && !irq && !count_zero && !atn_out;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset incomplete");
  property p_undef;
    cmd_wr && pwdata[6:0] == 7'h7F && !busy_r && quiet |=> !cmd_start ##[0:1] irq;
  endproperty
  a_undef: assert property (p_undef) else $error("bad code not refused");
  property p_nop_launch;
    cmd_wr && pwdata[6:0] == 7'h00 && !busy_r && quiet |=> cmd_start && cmd_code == $past(pwdata[7:0]);
  endproperty
  a_nop_launch: assert property (p_nop_launch) else $error("no-op not launched");
endmodule

bind scds_top scds_top_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .cmd_done(cmd_done), .done_cause(done_cause), .byte_xfer(byte_xfer),
  .irq(irq), .atn_out(atn_out), .cmd_start(cmd_start), .cmd_code(cmd_code),
  .dma_stop(dma_stop), .soft_reset(soft_reset), .count_zero(count_zero));

// *** scds_scsi_peer.sv ***
// Far-side bus model: another device steering phase and bus reset lines.
// Pins move with odd skew, unrelated to pclk, as real pins would.
`timescale 1ns/1ps
module scds_scsi_peer (
  input wire [2:0] phase_req,
  input wire rst_req,
  output logic [2:0] scsi_phase_pin,
  output logic scsi_rst_pin
);
  initial scsi_phase_pin = 3'h0;
  initial scsi_rst_pin = 1'b0;
  always @(phase_req) scsi_phase_pin <= #3 phase_req;
  always @(rst_req) scsi_rst_pin <= #7 rst_req;
endmodule

// *** scds_top_bench.sv ***
// Bench for the command decoder and status block: drives APB, engine
// inputs and a bus peer; a watcher checks reads and launches in order.
`timescale 1ns/1ps
`include "scds_defs.vh"
module scds_top_bench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [1:0] em = 2'h1;
  logic done = 0, bx = 0, par = 0, dre = 0, ovf = 0, cdb = 0, rreq = 0, swr = 0, spe = 0;
  logic [5:0] dc = 6'h00;
  logic [2:0] grp = 3'h0, ph = 3'h0;
  wire [31:0] prdata;
  wire pready, pslverr, irq, atn_out, cmd_start, dma_stop, soft_reset, count_zero, rst_pin;
  wire [7:0] cmd_code;
  wire [3:0] cdb_len;
  wire [2:0] target_id, ph_pin;
  logic [9:0] rq[$];
  logic [7:0] cq[$];
  logic [9:0] e;
  logic [7:0] ec;
  logic [31:0] r;
  int fail_count = 0, n_tests = 0, i;
  logic [7:0] codes [29] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h10, 8'h11, 8'h12, 8'h18,
    8'h1A, 8'h1B, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h27, 8'h28, 8'h29, 8'h2A,
    8'h2B, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46};
  logic [3:0] lens [8] = '{4'h6, 4'hA, 4'hA, 4'h6, 4'h6, 4'hC, 4'h6, 4'hA};
  scds_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .engine_mode(em), .cmd_done(done), .done_cause(dc), .byte_xfer(bx),
    .step_wr(swr), .step_in(grp), .parity_err(par), .dir_err(dre), .fifo_ovf(ovf),
    .sync_phase_err(spe), .cdb_seen(cdb), .cdb_group(grp), .scsi_phase_pin(ph_pin),
    .scsi_rst_pin(rst_pin), .irq(irq), .atn_out(atn_out), .cmd_start(cmd_start),
    .cmd_code(cmd_code), .dma_stop(dma_stop), .soft_reset(soft_reset),
    .count_zero(count_zero), .cdb_len(cdb_len), .target_id(target_id));
  scds_scsi_peer i_peer (.phase_req(ph), .rst_req(rreq), .scsi_phase_pin(ph_pin),
    .scsi_rst_pin(rst_pin));
  initial forever #5 pclk = ~pclk;
  task check(input logic [8:0] got, input logic [8:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task test_done;
    if (fail_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task apb(input logic w, input logic [3:0] x, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, x, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (pready !== 1'b1) begin
      check(9'h000, 9'h001);
      test_done();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [3:0] x, input logic [9:0] ex);
    rq.push_back(ex);
    apb(1'b0, x, 8'h00);
  endtask
  task cmd(input logic [7:0] c, input logic ok);
    if (ok) cq.push_back(c);
    apb(1'b1, `SCDS_IDX_CMD, c);
  endtask
  task fin(input logic [5:0] c);
    @(posedge pclk);
    done <= 1'b1;
    dc <= c;
    @(posedge pclk);
    done <= 1'b0;
  endtask
  // Results arrive in issue order, so the oldest note always matches
  always @(posedge pclk) begin
    if (presetn && psel && penable && pready && !pwrite) begin
      e = rq.size() ? rq.pop_front() : 10'h3FF;
      if (e[9]) check({pslverr, prdata[7:0]}, e[8:0]);
      else check(9'(pslverr), 9'(e[8]));
    end
    if (presetn && (cmd_start || soft_reset || dma_stop)) begin
      ec = cq.size() ? cq.pop_front() : 8'hFF;
      check(9'(cmd_start ? cmd_code : {5'h00, dma_stop, soft_reset, 1'b0}), 9'(ec));
    end
  end
  initial begin
    r = $urandom(32'hbffc);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    r = $urandom;
    apb(1'b1, `SCDS_IDX_TARGET_ID, r[7:0]);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    #1 check(9'(target_id), 9'(r[2:0]));
    rd(4'h2, 10'h100);
    r = $urandom_range(9, 2);
    apb(1'b1, `SCDS_IDX_COUNT_LO, r[7:0]);
    apb(1'b1, `SCDS_IDX_COUNT_HI, 8'h00);
    cmd(8'h90, 1'b1);
    #1 check(9'(count_zero), 9'h000);
    rd(`SCDS_IDX_COUNT_LO, {2'b10, r[7:0]});
    repeat (r[3:0]) begin
      @(posedge pclk);
      bx <= 1'b1;
      @(posedge pclk);
      bx <= 1'b0;
    end
    rd(`SCDS_IDX_STATUS, 10'h210);
    fin(6'h08);
    rd(`SCDS_IDX_STATUS, 10'h290);
    rd(`SCDS_IDX_CAUSE, 10'h208);
    rd(`SCDS_IDX_STATUS, 10'h210);
    cmd(8'h00, 1'b1);
    fin(6'h00);
    #1 check(9'(count_zero), 9'h001);
    cmd(8'h80, 1'b1);
    #1 check(9'(count_zero), 9'h000);
    fin(6'h00);
    foreach (codes[k]) begin
      em <= codes[k][6] ? 2'h0 : codes[k][5] ? 2'h2 : 2'h1;
      cmd(codes[k], 1'b1);
      fin(6'h00);
    end
    em <= 2'h0;
    cmd(8'h10, 1'b0);
    repeat (2) @(posedge pclk);
    rd(`SCDS_IDX_CAUSE, 10'h240);
    cmd(8'h7F, 1'b0);
    repeat (2) @(posedge pclk);
    rd(`SCDS_IDX_CAUSE, 10'h240);
    em <= 2'h1;
    apb(1'b1, `SCDS_IDX_CTRL_ONE, 8'h50);
    apb(1'b1, `SCDS_IDX_CTRL_TWO, 8'h08);
    @(posedge pclk);
    par <= 1'b1;
    dre <= 1'b1;
    ovf <= 1'b1;
    @(posedge pclk);
    par <= 1'b0;
    dre <= 1'b0;
    ovf <= 1'b0;
    for (i = 0; i < 8; i++) begin
      @(posedge pclk);
      cdb <= 1'b1;
      grp <= i[2:0] ^ 3'h2;
      @(posedge pclk);
      cdb <= 1'b0;
      #1 check(9'(cdb_len), 9'(lens[i ^ 2]));
    end
    check(9'({atn_out, irq}), 9'h002);
    rd(`SCDS_IDX_STATUS, 10'h268);
    rd(`SCDS_IDX_CAUSE, 10'h200);
    rd(`SCDS_IDX_STATUS, 10'h200);
    // Step input follows grp, left at group 5 by the loop above
    @(posedge pclk);
    spe <= 1'b1;
    swr <= 1'b1;
    @(posedge pclk);
    spe <= 1'b0;
    swr <= 1'b0;
    rd(`SCDS_IDX_STEP, 10'h205);
    rd(`SCDS_IDX_STATUS, 10'h240);
    rd(`SCDS_IDX_CAUSE, 10'h200);
    rd(`SCDS_IDX_STEP, 10'h200);
    cmd(8'h11, 1'b1);
    cmd(8'h12, 1'b0);
    cmd(8'h1B, 1'b1);
    fin(6'h00);
    fin(6'h00);
    rd(`SCDS_IDX_CMD, 10'h21B);
    rd(`SCDS_IDX_STATUS, 10'h240);
    rd(`SCDS_IDX_CAUSE, 10'h200);
    r = $urandom;
    ph <= r[2:0];
    repeat (4) @(posedge pclk);
    rd(`SCDS_IDX_STATUS, {7'h40, r[2:0]});
    apb(1'b1, `SCDS_IDX_CTRL_TWO, 8'h48);
    fin(6'h00);
    ph <= ~r[2:0];
    repeat (4) @(posedge pclk);
    rd(`SCDS_IDX_STATUS, {7'h40, r[2:0]});
    rd(`SCDS_IDX_CAUSE, 10'h200);
    rd(`SCDS_IDX_STATUS, {7'h40, ~r[2:0]});
    fin(6'h08);
    fin(6'h04);
    rd(`SCDS_IDX_CAUSE, 10'h208);
    rd(`SCDS_IDX_CAUSE, 10'h204);
    rreq <= 1'b1;
    repeat (8) @(posedge pclk);
    rreq <= 1'b0;
    rd(`SCDS_IDX_CAUSE, 10'h280);
    repeat (2) @(posedge pclk);
    check(9'(rq.size() + cq.size()), 9'h000);
    test_done();
  end
endmodule
